// *** core/sal_consts.svh ***
// Offsets, field positions, reset values and fixed codes of the access filter.
// Assumes byte addresses on a 13-bit register port, one 32-bit word each.
`ifndef SAL_CONSTS_SVH
`define SAL_CONSTS_SVH

`define SAL_ADDR_W       13
`define SAL_DCTL_OFS     13'h0000
`define SAL_TYPE_OFS     13'h0004
`define SAL_GRP_OFS      13'h0080
`define SAL_SEN_OFS      13'h0100
`define SAL_CEN_OFS      13'h0180
`define SAL_SPND_OFS     13'h0200
`define SAL_CPND_OFS     13'h0280
`define SAL_SACT_OFS     13'h0300
`define SAL_CACT_OFS     13'h0380
`define SAL_PRIO_OFS     13'h0400
`define SAL_TGT_OFS      13'h0800
`define SAL_CFG_OFS      13'h0C00
`define SAL_SGI_OFS      13'h0F00
`define SAL_CCTL_OFS     13'h1000
`define SAL_PMR_OFS      13'h1004
`define SAL_BPR_OFS      13'h1008
`define SAL_ACK_OFS      13'h100C
`define SAL_EOI_OFS      13'h1010
`define SAL_RPR_OFS      13'h1014
`define SAL_TOP_OFS      13'h1018
`define SAL_ABPR_OFS     13'h101C
`define SAL_AACK_OFS     13'h1020
`define SAL_AEOI_OFS     13'h1024
`define SAL_ATOP_OFS     13'h1028
`define SAL_NSAP_OFS     13'h10E0
`define SAL_NSAP_WORDS   4
`define SAL_TYPE_LOCKABLE_IRQ_COUNT_LSB 11
`define SAL_TYPE_SEC_BIT 10
`define SAL_TYPE_CPU_LSB 5
`define SAL_SGI_NONSECURE_SGI_ATTRIBUTE    15
`define SAL_CCTL_W       11
`define SAL_CCTL_LOCK    11'h027D
`define SAL_CCTL_RST     11'h0000
`define SAL_PRIO_HALF    8'h80
`define SAL_CFG_RST      2'h0
`define SAL_CFG_SGI      2'h2

`endif

// *** core/sal_pkg.sv ***
// Types shared by the access filter and its address decoder.
// Assumes nothing beyond the constants header.
package sal_pkg;

	// Register region hit by one access.
	typedef enum logic [4:0] {
		SAL_R_NONE, SAL_R_DCTL, SAL_R_TYPE, SAL_R_GRP, SAL_R_SEN,
		SAL_R_CEN, SAL_R_SPND, SAL_R_CPND, SAL_R_SACT, SAL_R_CACT,
		SAL_R_PRIO, SAL_R_TGT, SAL_R_CFG, SAL_R_SGI, SAL_R_CCTL,
		SAL_R_PMR, SAL_R_BPR, SAL_R_RPR, SAL_R_ABPR, SAL_R_EXT_S,
		SAL_R_EXT_C
	} sal_region_t;

endpackage

// *** core/sal_access_if.sv ***
// Carries one register address to the decoder and its region back.
// Assumes both ends run on the same clock; the path is combinational.
`timescale 1ns/1ps
interface sal_access_if;
	logic [12:0]              addr;
	sal_pkg::sal_region_t     region;
	logic [8:0]               index;

	modport dec
	(
		input  addr,
		output region,
		output index
	);
	modport core
	(
		output addr,
		input  region,
		input  index
	);
endinterface

// *** core/sal_decode.sv ***
// Address decoder: maps a byte address to a register region and word index.
// Assumes word-aligned accesses; the low two address bits are ignored.
`timescale 1ns/1ps
`include "sal_consts.svh"
module sal_decode
(
	sal_access_if.dec acc
);
	// True when the address falls in a run of words starting at base.
	function automatic logic in_run(input logic [12:0] a,
		input logic [12:0] base, input int unsigned words);
		logic [12:0] top;
		top = base + 13'(words * 4);
		return (a >= base) && (a < top);
	endfunction

	wire [12:0] wa = {acc.addr[12:2], 2'b00};

	// Block regions of the per-interrupt tables.
	wire h_grp  = in_run(wa, `SAL_GRP_OFS, 32);
	wire h_sen  = in_run(wa, `SAL_SEN_OFS, 32);
	wire h_cen  = in_run(wa, `SAL_CEN_OFS, 32);
	wire h_spnd = in_run(wa, `SAL_SPND_OFS, 32);
	wire h_cpnd = in_run(wa, `SAL_CPND_OFS, 32);
	wire h_sact = in_run(wa, `SAL_SACT_OFS, 32);
	wire h_cact = in_run(wa, `SAL_CACT_OFS, 32);
	wire h_prio = in_run(wa, `SAL_PRIO_OFS, 256);
	wire h_tgt  = in_run(wa, `SAL_TGT_OFS, 256);
	wire h_cfg  = in_run(wa, `SAL_CFG_OFS, 64);
	wire h_nsap = in_run(wa, `SAL_NSAP_OFS, `SAL_NSAP_WORDS);
	// Aliased views and the non-secure active priorities are secure-only.
	wire h_ext_s = (wa == `SAL_AACK_OFS) || (wa == `SAL_AEOI_OFS) ||
		(wa == `SAL_ATOP_OFS) || h_nsap;
	wire h_ext_c = (wa == `SAL_ACK_OFS) || (wa == `SAL_EOI_OFS) ||
		(wa == `SAL_TOP_OFS);

	// Tables sit on bases aligned to their size, so the index is low bits.
	wire [7:0] imask = (h_prio || h_tgt) ? 8'hFF : h_cfg ? 8'h3F : 8'h1F;

	assign acc.index = {1'b0, wa[9:2] & imask};
	assign acc.region =
		(wa == `SAL_DCTL_OFS) ? sal_pkg::SAL_R_DCTL :
		(wa == `SAL_TYPE_OFS) ? sal_pkg::SAL_R_TYPE :
		h_grp  ? sal_pkg::SAL_R_GRP  : h_sen  ? sal_pkg::SAL_R_SEN  :
		h_cen  ? sal_pkg::SAL_R_CEN  : h_spnd ? sal_pkg::SAL_R_SPND :
		h_cpnd ? sal_pkg::SAL_R_CPND : h_sact ? sal_pkg::SAL_R_SACT :
		h_cact ? sal_pkg::SAL_R_CACT : h_prio ? sal_pkg::SAL_R_PRIO :
		h_tgt  ? sal_pkg::SAL_R_TGT  : h_cfg  ? sal_pkg::SAL_R_CFG  :
		(wa == `SAL_SGI_OFS)  ? sal_pkg::SAL_R_SGI  :
		(wa == `SAL_CCTL_OFS) ? sal_pkg::SAL_R_CCTL :
		(wa == `SAL_PMR_OFS)  ? sal_pkg::SAL_R_PMR  :
		(wa == `SAL_BPR_OFS)  ? sal_pkg::SAL_R_BPR  :
		(wa == `SAL_RPR_OFS)  ? sal_pkg::SAL_R_RPR  :
		(wa == `SAL_ABPR_OFS) ? sal_pkg::SAL_R_ABPR :
		h_ext_s ? sal_pkg::SAL_R_EXT_S :
		h_ext_c ? sal_pkg::SAL_R_EXT_C : sal_pkg::SAL_R_NONE;
endmodule

// *** core/sal_filter.sv ***
// Security access filter and lockdown logic of an interrupt controller.
// Assumes one requester access per cycle tagged with security and CPU.
// Operation
// - Type security bit reads one, writes ignored.
// - Banked copy chosen by access security.
// - Secure-only: non-secure reads zero, writes dropped.
// - Private and software interrupts banked per CPU.
// - Group 1 priority range is half.
// - Group, aliased, active-priority registers secure-only.
// - Controls, binary point banked; rest common.
// - Lockable count field; trigger attribute bit.
// - Non-secure sees no Group 0 fields.
// - Non-secure priority uses shifted view.
// - Low mask: non-secure reads zero, writes ignored.
// - High mask: non-secure view, stays upper.
// - Lockdown input high blocks locked writes.
// - Lockable interrupts 32 to 31 plus count.
// - Zero count: lockdown locks nothing.
// - Lock Group 0 enable, secure CPU bits.
// - Lock fields of lockable Group 0 interrupts.
// - Lock group field; moved interrupts lock.
// - Locked writes dropped silently.
// - Grouping supported; each interrupt assignable.
// - Reset clears non-secure Group 1 enables.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sal_consts.svh"
module sal_filter
#(
	parameter int unsigned NCPU       = 2,
	parameter int unsigned NUM_SPI    = 32,
	parameter logic [4:0]  LOCKABLE_IRQ_COUNT_COUNT = 5'h1F,
	parameter logic        SEC_PRESENT = 1'b1,
	parameter int unsigned CW         = (NCPU > 1) ? $clog2(NCPU) : 1,
	parameter int unsigned NSLOT      = NCPU * 32 + NUM_SPI
)
(
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire logic [12:0]          reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	input  wire logic                 reg_secure_i,
	input  wire logic [CW-1:0]        reg_cpu_i,
	output logic      [31:0]          reg_rdata_o,
	input  wire logic                 lockdown_request_i,
	input  wire logic [NCPU*8-1:0]    running_prio_i,
	input  wire logic [31:0]          ext_rdata_i,
	output logic                      ext_wr_o,
	output logic                      ext_rd_o,
	output logic                      ext_secure_o,
	output logic      [CW-1:0]        ext_cpu_o,
	output logic      [12:0]          ext_addr_o,
	output logic      [31:0]          ext_wdata_o,
	output logic                      group0_forward_enable_o,
	output logic                      group1_forward_enable_o,
	output logic      [NCPU*11-1:0]   cpu_port_control_o,
	output logic      [NCPU*8-1:0]    priority_mask_o,
	output logic      [NSLOT-1:0]     irq_group_o,
	output logic      [NSLOT-1:0]     irq_enable_o,
	output logic      [NSLOT-1:0]     irq_pending_o,
	output logic      [NSLOT-1:0]     irq_active_o,
	output logic                      sgi_valid_o,
	output logic      [31:0]          sgi_word_o,
	output logic                      lockdown_active_o
);
	localparam int unsigned NUM_IRQ = 32 + NUM_SPI;

	sal_access_if acc();

	sal_decode u_decode
	(
		.acc (acc.dec)
	);

	// Per-interrupt state, one slot per banked copy or shared interrupt.
	logic [NSLOT-1:0]  grp_r;
	logic [NSLOT-1:0]  en_r;
	logic [NSLOT-1:0]  pnd_r;
	logic [NSLOT-1:0]  act_r;
	logic [7:0]        prio_r [NSLOT];
	logic [7:0]        tgt_r  [NSLOT];
	logic [1:0]        cfg_r  [NSLOT];
	// Banked control state, lockdown flops, trigger and read registers.
	logic              g0_en_r;
	logic              g1_en_r;
	logic [10:0]       cctl_r   [NCPU];
	logic [7:0]        pmr_r    [NCPU];
	logic [2:0]        bpr_s_r  [NCPU];
	logic [2:0]        bpr_ns_r [NCPU];
	logic              lock_m_r;
	logic              lock_s_r;
	logic              sgi_valid_r;
	logic [31:0]       sgi_word_r;
	logic [31:0]       rdata_r;
	logic [31:0]       rd_nxt;

	assign acc.addr = reg_addr_i;

	// Lockdown pin crosses in through two flops before anything reads it.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			lock_m_r <= 1'b0;
			lock_s_r <= 1'b0;
		end
		else
		begin
			lock_m_r <= lockdown_request_i;
			lock_s_r <= lock_m_r;
		end
	end

	// A zero lockable count disables lockdown entirely.
	wire lock_on = lock_s_r && (LOCKABLE_IRQ_COUNT_COUNT != 5'h00);
	// Without the security option every access behaves as secure.
	wire acc_ns  = SEC_PRESENT && !reg_secure_i;
	wire [CW-1:0] cpu = reg_cpu_i;
	wire wr = reg_wr_i;
	sal_pkg::sal_region_t rg;
	assign rg = acc.region;
	wire [8:0] idx = acc.index;

	// Slot of an interrupt: private ones per requesting CPU.
	function automatic int unsigned slot(input logic [CW-1:0] c,
		input int unsigned irq);
		return (irq < 32) ? int'(c) * 32 + irq : NCPU * 32 + irq - 32;
	endfunction

	// Lockable Group 0 shared interrupt under an active lockdown.
	function automatic logic locked(input int unsigned irq, input logic g);
		return lock_on && !g && (irq >= 32) &&
			(irq <= 31 + int'(LOCKABLE_IRQ_COUNT_COUNT));
	endfunction

	// Field visible to this access: Group 0 fields hidden from non-secure.
	function automatic logic fld_vis(input logic g);
		return !acc_ns || g;
	endfunction

	// Non-secure priority view: half range, always upper half on write.
	function automatic logic [7:0] ns_rd(input logic [7:0] v);
		return {v[6:0], 1'b0};
	endfunction
	function automatic logic [7:0] ns_wr(input logic [7:0] w);
		return {1'b1, w[7:1]};
	endfunction

	// Non-secure view of the CPU control: group 1 bits moved down.
	function automatic logic [31:0] cctl_ns(input logic [10:0] c);
		return {22'h00_0000, c[10], 2'b00, c[8:7], 4'h0, c[1]};
	endfunction

	// Secure accesses to aliased registers, and all accesses to CPU-side queue registers, pass out unchanged.
	wire ext_hit = (rg == sal_pkg::SAL_R_EXT_C) ||
		((rg == sal_pkg::SAL_R_EXT_S) && !acc_ns);
	assign ext_wr_o     = wr && ext_hit;
	assign ext_rd_o     = reg_rd_i && ext_hit;
	assign ext_secure_o = reg_secure_i;
	assign ext_cpu_o    = cpu;
	assign ext_addr_o   = reg_addr_i;
	assign ext_wdata_o  = reg_wdata_i;

	wire [7:0] pmr_cur = pmr_r[cpu];
	wire [7:0] rpr_cur = running_prio_i[int'(cpu)*8 +: 8];
	wire pmr_hi = pmr_cur >= `SAL_PRIO_HALF;

	// Per-interrupt tables: bit, byte and two-bit fields per word.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			grp_r <= '0;
			en_r  <= '0;
			pnd_r <= '0;
			act_r <= '0;
			for (int s = 0; s < NSLOT; s++)
			begin
				prio_r[s] <= 8'h00;
				tgt_r[s]  <= 8'h00;
				cfg_r[s]  <= `SAL_CFG_RST;
			end
		end
		else if (wr)
		begin
			for (int b = 0; b < 32; b++)
			begin
				automatic int unsigned irq = int'(idx) * 32 + b;
				automatic int unsigned s = slot(cpu, irq);
				if (irq < NUM_IRQ && reg_wdata_i[b] &&
					fld_vis(grp_r[s]) && !locked(irq, grp_r[s]))
				begin
					unique case (rg)
					sal_pkg::SAL_R_SEN:  en_r[s]  <= 1'b1;
					sal_pkg::SAL_R_CEN:  en_r[s]  <= 1'b0;
					sal_pkg::SAL_R_SPND: pnd_r[s] <= 1'b1;
					sal_pkg::SAL_R_CPND: pnd_r[s] <= 1'b0;
					sal_pkg::SAL_R_SACT: act_r[s] <= 1'b1;
					sal_pkg::SAL_R_CACT: act_r[s] <= 1'b0;
					default:             ;
					endcase
				end
				// Group field: secure only, locked while in Group 0.
				if (irq < NUM_IRQ && rg == sal_pkg::SAL_R_GRP && !acc_ns &&
					!locked(irq, grp_r[s]))
					grp_r[s] <= reg_wdata_i[b];
			end
			for (int k = 0; k < 4; k++)
			begin
				automatic int unsigned irq = int'(idx) * 4 + k;
				automatic int unsigned s = slot(cpu, irq);
				automatic logic [7:0] w = reg_wdata_i[k*8 +: 8];
				if (irq < NUM_IRQ && fld_vis(grp_r[s]) &&
					!locked(irq, grp_r[s]))
				begin
					if (rg == sal_pkg::SAL_R_PRIO)
						prio_r[s] <= acc_ns ? ns_wr(w) : w;
					if (rg == sal_pkg::SAL_R_TGT && irq >= 32)
						tgt_r[s] <= w;
				end
			end
			for (int k = 0; k < 16; k++)
			begin
				automatic int unsigned irq = int'(idx) * 16 + k;
				automatic int unsigned s = slot(cpu, irq);
				if (irq >= 32 && irq < NUM_IRQ && rg == sal_pkg::SAL_R_CFG &&
					fld_vis(grp_r[s]) && !locked(irq, grp_r[s]))
					cfg_r[s] <= reg_wdata_i[k*2 +: 2];
			end
		end
	end

	// Distributor control: secure copy holds both enables, non-secure one.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			g0_en_r <= 1'b0;
			g1_en_r <= 1'b0;
		end
		else if (wr && rg == sal_pkg::SAL_R_DCTL)
		begin
			if (acc_ns)
				g1_en_r <= reg_wdata_i[0];
			else
			begin
				g1_en_r <= reg_wdata_i[1];
				if (!lock_on)
					g0_en_r <= reg_wdata_i[0];
			end
		end
	end

	// Per-CPU interface state: control, mask and binary points.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			for (int c = 0; c < NCPU; c++)
			begin
				cctl_r[c]   <= `SAL_CCTL_RST;
				pmr_r[c]    <= 8'h00;
				bpr_s_r[c]  <= 3'h0;
				bpr_ns_r[c] <= 3'h0;
			end
		end
		else if (wr)
		begin
			unique case (rg)
			sal_pkg::SAL_R_CCTL:
				if (acc_ns)
					cctl_r[cpu] <= {reg_wdata_i[9], cctl_r[cpu][9],
						reg_wdata_i[6:5], cctl_r[cpu][6:2], reg_wdata_i[0],
						cctl_r[cpu][0]};
				else if (lock_on)
					cctl_r[cpu] <= (cctl_r[cpu] & `SAL_CCTL_LOCK) |
						(reg_wdata_i[10:0] & ~`SAL_CCTL_LOCK);
				else
					cctl_r[cpu] <= reg_wdata_i[10:0];
			sal_pkg::SAL_R_PMR:
				if (!acc_ns)
					pmr_r[cpu] <= reg_wdata_i[7:0];
				else if (pmr_hi)
					pmr_r[cpu] <= ns_wr(reg_wdata_i[7:0]);
			sal_pkg::SAL_R_BPR:
				if (acc_ns)
					bpr_ns_r[cpu] <= reg_wdata_i[2:0];
				else
					bpr_s_r[cpu] <= reg_wdata_i[2:0];
			sal_pkg::SAL_R_ABPR:
				if (!acc_ns)
					bpr_ns_r[cpu] <= reg_wdata_i[2:0];
			default: ;
			endcase
		end
	end

	// Software interrupt trigger: non-secure writers may only raise Group 1.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			sgi_valid_r <= 1'b0;
			sgi_word_r  <= 32'h0000_0000;
		end
		else
		begin
			sgi_valid_r <= wr && rg == sal_pkg::SAL_R_SGI;
			if (wr && rg == sal_pkg::SAL_R_SGI)
			begin
				sgi_word_r <= reg_wdata_i;
				sgi_word_r[`SAL_SGI_NONSECURE_SGI_ATTRIBUTE] <= reg_wdata_i[`SAL_SGI_NONSECURE_SGI_ATTRIBUTE] ||
					acc_ns;
			end
		end
	end

	// Read mux; filtered values are registered for the next cycle.
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		unique case (rg)
		sal_pkg::SAL_R_DCTL:
			rd_nxt = acc_ns ? {31'h0, g1_en_r} : {30'h0, g1_en_r, g0_en_r};
		sal_pkg::SAL_R_TYPE:
		begin
			rd_nxt[`SAL_TYPE_LOCKABLE_IRQ_COUNT_LSB +: 5] = SEC_PRESENT ? LOCKABLE_IRQ_COUNT_COUNT : 5'h00;
			rd_nxt[`SAL_TYPE_SEC_BIT] = SEC_PRESENT;
			rd_nxt[`SAL_TYPE_CPU_LSB +: 3] = 3'(NCPU - 1);
			rd_nxt[4:0] = 5'(NUM_IRQ / 32 - 1);
		end
		sal_pkg::SAL_R_GRP, sal_pkg::SAL_R_SEN, sal_pkg::SAL_R_CEN,
		sal_pkg::SAL_R_SPND, sal_pkg::SAL_R_CPND, sal_pkg::SAL_R_SACT,
		sal_pkg::SAL_R_CACT:
			for (int b = 0; b < 32; b++)
			begin
				automatic int unsigned irq = int'(idx) * 32 + b;
				automatic int unsigned s = slot(cpu, irq);
				if (irq < NUM_IRQ && fld_vis(grp_r[s]))
					unique case (rg)
					sal_pkg::SAL_R_GRP:
						rd_nxt[b] = !acc_ns && grp_r[s];
					sal_pkg::SAL_R_SEN, sal_pkg::SAL_R_CEN:
						rd_nxt[b] = en_r[s];
					sal_pkg::SAL_R_SPND, sal_pkg::SAL_R_CPND:
						rd_nxt[b] = pnd_r[s];
					default:
						rd_nxt[b] = act_r[s];
					endcase
			end
		sal_pkg::SAL_R_PRIO, sal_pkg::SAL_R_TGT:
			for (int k = 0; k < 4; k++)
			begin
				automatic int unsigned irq = int'(idx) * 4 + k;
				automatic int unsigned s = slot(cpu, irq);
				if (irq < NUM_IRQ && fld_vis(grp_r[s]))
				begin
					if (rg == sal_pkg::SAL_R_TGT)
						rd_nxt[k*8 +: 8] = (irq < 32) ?
							8'(1 << int'(cpu)) : tgt_r[s];
					else
						rd_nxt[k*8 +: 8] = acc_ns ? ns_rd(prio_r[s]) :
							prio_r[s];
				end
			end
		sal_pkg::SAL_R_CFG:
			for (int k = 0; k < 16; k++)
			begin
				automatic int unsigned irq = int'(idx) * 16 + k;
				automatic int unsigned s = slot(cpu, irq);
				if (irq < NUM_IRQ && fld_vis(grp_r[s]))
					rd_nxt[k*2 +: 2] = (irq < 16) ? `SAL_CFG_SGI :
						(irq < 32) ? `SAL_CFG_RST : cfg_r[s];
			end
		sal_pkg::SAL_R_CCTL:
			rd_nxt = acc_ns ? cctl_ns(cctl_r[cpu]) :
				{21'h00_0000, cctl_r[cpu]};
		sal_pkg::SAL_R_PMR:
			rd_nxt[7:0] = !acc_ns ? pmr_cur :
				pmr_hi ? ns_rd(pmr_cur) : 8'h00;
		sal_pkg::SAL_R_RPR:
			rd_nxt[7:0] = !acc_ns ? rpr_cur :
				pmr_hi ? ns_rd(rpr_cur) : 8'h00;
		sal_pkg::SAL_R_BPR:
			rd_nxt[2:0] = acc_ns ? bpr_ns_r[cpu] : bpr_s_r[cpu];
		sal_pkg::SAL_R_ABPR:
			rd_nxt[2:0] = acc_ns ? 3'h0 : bpr_ns_r[cpu];
		sal_pkg::SAL_R_EXT_S, sal_pkg::SAL_R_EXT_C:
			rd_nxt = ext_hit ? ext_rdata_i : 32'h0000_0000;
		default:
			rd_nxt = 32'h0000_0000;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			rdata_r <= 32'h0000_0000;
		else
			rdata_r <= reg_rd_i ? rd_nxt : 32'h0000_0000;
	end

	// State outputs for the prioritisation logic downstream.
	always_comb
	begin
		for (int c = 0; c < NCPU; c++)
		begin
			cpu_port_control_o[c*11 +: 11] = cctl_r[c];
			priority_mask_o[c*8 +: 8]      = pmr_r[c];
		end
	end

	assign reg_rdata_o             = rdata_r;
	assign group0_forward_enable_o = g0_en_r;
	assign group1_forward_enable_o = g1_en_r;
	assign irq_group_o             = grp_r;
	assign irq_enable_o            = en_r;
	assign irq_pending_o           = pnd_r;
	assign irq_active_o            = act_r;
	assign sgi_valid_o             = sgi_valid_r;
	assign sgi_word_o              = sgi_word_r;
	assign lockdown_active_o       = lock_on;
endmodule

// *** testbench/sal_far_side_model.sv ***
// Far side of the filter: outer CPU-interface logic and lockdown source.
// Assumes one clock shared with the filter; strobes are combinational.
`timescale 1ns/1ps
module sal_far_side_model
(
	input  wire logic        clk_sys_i,
	input  wire logic        ext_rd_i,
	input  wire logic [12:0] ext_addr_i,
	input  wire logic        lock_cmd_i,
	output logic      [31:0] ext_rdata_o,
	output logic             lockdown_o = 1'b0
);
	logic [31:0] idle_r = 32'h3C3C_A5A5;

	// The pin moves only after an edge, and only when boot code asks for it.
	always @(posedge clk_sys_i)
	begin
		lockdown_o <= lock_cmd_i;
		idle_r     <= ~idle_r;
	end

	// Outside a read the lines toggle, so a late sample cannot pass by luck.
	assign ext_rdata_o = ext_rd_i ? {19'h2_D000, ext_addr_i} : idle_r;
endmodule

// *** testbench/sal_filter_asserts.sv ***
// Concurrent checks on the access filter, seen through its top ports.
// Assumes the bind below hands on the filter's own parameter values.
`timescale 1ns/1ps
module sal_filter_asserts
#(
	parameter int unsigned NCPU       = 2,
	parameter int unsigned CW         = 1,
	parameter logic [4:0]  LOCKABLE_IRQ_COUNT_COUNT = 5'h1F
)
(
	input wire logic              clk_sys_i,
	input wire logic              rstn_i,
	input wire logic [12:0]       reg_addr_i,
	input wire logic [31:0]       reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic              reg_secure_i,
	input wire logic [CW-1:0]     reg_cpu_i,
	input wire logic [31:0]       reg_rdata_o,
	input wire logic              lockdown_request_i,
	input wire logic              ext_wr_o,
	input wire logic              ext_rd_o,
	input wire logic              group1_forward_enable_o,
	input wire logic [NCPU*8-1:0] priority_mask_o,
	input wire logic              sgi_valid_o,
	input wire logic [31:0]       sgi_word_o,
	input wire logic              lockdown_active_o
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	// Decoded strobes that several checks share.
	wire ns_pmr = reg_wr_i && !reg_secure_i && reg_cpu_i == '0
		&& reg_addr_i == 13'h1004;
	wire sgi_wr = reg_wr_i && reg_addr_i == 13'h0F00;

	a_type_word: assert property (
		reg_rd_i && reg_addr_i[12:2] == 11'h001
		|=> reg_rdata_o[15:10] == {LOCKABLE_IRQ_COUNT_COUNT, 1'b1})
		else $error("type word wrong");
	a_group_hidden: assert property (
		reg_rd_i && !reg_secure_i && reg_addr_i[12:7] == 6'h01
		|=> reg_rdata_o == 32'h0000_0000)
		else $error("group word visible");
	a_alias_blocked: assert property (
		(reg_rd_i || reg_wr_i) && !reg_secure_i
		&& reg_addr_i inside {[13'h1020:13'h102B], [13'h10E0:13'h10EF]}
		|-> !(ext_rd_o || ext_wr_o))
		else $error("alias forwarded");
	a_mask_low_kept: assert property (
		ns_pmr && !priority_mask_o[7] |=> $stable(priority_mask_o))
		else $error("low mask changed");
	a_mask_high_view: assert property (
		ns_pmr && priority_mask_o[7]
		|=> priority_mask_o[7:0] == {1'b1, $past(reg_wdata_i[7:1])})
		else $error("upper mask wrong");
	a_sgi_pulse: assert property (
		sgi_wr |=> sgi_valid_o
		&& sgi_word_o[14:0] == $past(reg_wdata_i[14:0]))
		else $error("trigger not passed");
	a_sgi_nonsecure_sgi_attribute: assert property (
		sgi_wr && !reg_secure_i |=> sgi_word_o[15])
		else $error("attribute bit clear");
	a_lock_follows: assert property (
		lockdown_request_i[*3]
		|=> lockdown_active_o == (LOCKABLE_IRQ_COUNT_COUNT != 5'h00))
		else $error("lock not following");
	a_lock_drops: assert property (
		(!lockdown_request_i)[*3] |=> !lockdown_active_o)
		else $error("lock held");
	a_g1_reset: assert property (
		!$past(rstn_i) |-> !group1_forward_enable_o)
		else $error("group 1 enable set");

	// Main scenarios that the bench is expected to reach.
	c_locked_write: cover property (reg_wr_i && lockdown_active_o);
	c_sgi: cover property (sgi_valid_o);
	c_ext_read: cover property (ext_rd_o);
endmodule

bind sal_filter sal_filter_asserts #(.NCPU(NCPU), .CW(CW),
	.LOCKABLE_IRQ_COUNT_COUNT(LOCKABLE_IRQ_COUNT_COUNT)) u_asserts (.*);

// *** testbench/test_secure_access_lockdown.sv ***
// Self-checking bench for the access filter and its lockdown path.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_secure_access_lockdown;
	logic        clk_sys_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [12:0] reg_addr_i = 13'h0000;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        reg_secure_i = 1'b0;
	logic [0:0]  reg_cpu_i = 1'b0;
	logic        lock_cmd = 1'b0;
	logic        cur_cpu = 1'b0;
	logic [31:0] d;
	wire  [31:0] rdata, ext_rdata, sgi_word;
	wire  [21:0] cpu_ctl;
	wire  [15:0] pmask;
	wire  [12:0] ext_addr;
	wire         lock_pin, ext_rd, sgi_valid, lock_act, g0_en, g1_en;
	int          errors = 0;
	int          checks = 0;

	// Free-running 50 MHz clock.
	always #10 clk_sys_i = ~clk_sys_i;

	sal_filter u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_secure_i(reg_secure_i),
		.reg_cpu_i(reg_cpu_i), .reg_rdata_o(rdata),
		.lockdown_request_i(lock_pin), .running_prio_i(16'h00C4),
		.ext_rdata_i(ext_rdata), .ext_wr_o(), .ext_rd_o(ext_rd),
		.ext_secure_o(), .ext_cpu_o(), .ext_addr_o(ext_addr), .ext_wdata_o(),
		.group0_forward_enable_o(g0_en), .group1_forward_enable_o(g1_en),
		.cpu_port_control_o(cpu_ctl), .priority_mask_o(pmask),
		.irq_group_o(), .irq_enable_o(), .irq_pending_o(), .irq_active_o(),
		.sgi_valid_o(sgi_valid), .sgi_word_o(sgi_word),
		.lockdown_active_o(lock_act));

	sal_far_side_model u_far (.clk_sys_i(clk_sys_i), .ext_rd_i(ext_rd),
		.ext_addr_i(ext_addr), .lock_cmd_i(lock_cmd), .ext_rdata_o(ext_rdata),
		.lockdown_o(lock_pin));

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One comparison; a mismatch is reported at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus cycle; outputs are sampled 1 ns after the answering edge.
	task automatic bus(input logic r, input logic [12:0] a,
		input logic [31:0] w, input logic s);
		@(posedge clk_sys_i);
		reg_rd_i <= r;
		reg_wr_i <= !r;
		reg_addr_i <= a;
		reg_wdata_i <= w;
		reg_secure_i <= s;
		reg_cpu_i <= cur_cpu;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		reg_wr_i <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wr(input logic [12:0] a, input logic [31:0] w,
		input logic s);
		bus(1'b0, a, w, s);
	endtask

	task automatic rd(input logic [12:0] a, input logic s,
		input logic [31:0] e);
		bus(1'b1, a, 32'h0000_0000, s);
		chk(d, e);
	endtask

	// Type word is common and ignores writes; size field masked off.
	task automatic t_type();
		wr(13'h0004, 32'h0000_0000, 1'b1);
		for (int s = 0; s < 2; s++)
		begin
			bus(1'b1, 13'h0004, 32'h0000_0000, s[0]);
			chk(d & 32'hFFFF_FFE0, 32'h0000_FC20);
		end
	endtask

	// Banked controls and binary point, and its aliased view.
	task automatic t_bank();
		chk({30'h0, g1_en, g0_en}, 32'h0000_0000);
		wr(13'h0000, 32'h0000_0003, 1'b1);
		rd(13'h0000, 1'b0, 32'h0000_0001);
		wr(13'h0000, 32'h0000_0000, 1'b0);
		rd(13'h0000, 1'b1, 32'h0000_0001);
		chk({30'h0, g1_en, g0_en}, 32'h0000_0001);
		wr(13'h1008, 32'h0000_0003, 1'b1);
		wr(13'h1008, 32'h0000_0004, 1'b0);
		rd(13'h101C, 1'b1, 32'h0000_0004);
		rd(13'h1008, 1'b1, 32'h0000_0003);
		rd(13'h101C, 1'b0, 32'h0000_0000);
	endtask

	// Group word hidden from non-secure and banked per processor.
	task automatic t_secure_only();
		wr(13'h0080, 32'hFFFF_0000, 1'b1);
		wr(13'h0080, 32'h0000_0000, 1'b0);
		rd(13'h0080, 1'b0, 32'h0000_0000);
		rd(13'h0080, 1'b1, 32'hFFFF_0000);
		cur_cpu = 1'b1;
		rd(13'h0080, 1'b1, 32'h0000_0000);
		cur_cpu = 1'b0;
	endtask

	// Irq 32 stays Group 0, irq 33 goes to Group 1.
	task automatic t_fields();
		wr(13'h0084, 32'h0000_0002, 1'b1);
		wr(13'h0104, 32'h0000_0003, 1'b0);
		rd(13'h0104, 1'b0, 32'h0000_0002);
		rd(13'h0104, 1'b1, 32'h0000_0002);
		wr(13'h0420, 32'h0000_4040, 1'b0);
		rd(13'h0420, 1'b0, 32'h0000_4000);
		rd(13'h0420, 1'b1, 32'h0000_A000);
	endtask

	// Mask in lower half, then upper half, running priority alongside.
	task automatic t_mask();
		wr(13'h1004, 32'h0000_00FF, 1'b0);
		rd(13'h1004, 1'b0, 32'h0000_0000);
		rd(13'h1014, 1'b0, 32'h0000_0000);
		chk({24'h0, pmask[7:0]}, 32'h0000_0000);
		wr(13'h1004, 32'h0000_0090, 1'b1);
		rd(13'h1004, 1'b0, 32'h0000_0020);
		wr(13'h1004, 32'h0000_0040, 1'b0);
		chk({24'h0, pmask[7:0]}, 32'h0000_00A0);
		rd(13'h1014, 1'b0, 32'h0000_0088);
		rd(13'h1014, 1'b1, 32'h0000_00C4);
	endtask

	// Trigger word, forwarded reads and an unmapped address.
	task automatic t_sgi_ext();
		wr(13'h0F00, 32'h0001_0003, 1'b1);
		chk({sgi_valid, sgi_word[30:0]}, 32'h8001_0003);
		wr(13'h0F00, 32'h0001_0003, 1'b0);
		chk(sgi_word, 32'h0001_8003);
		rd(13'h1020, 1'b1, 32'h5A00_1020);
		rd(13'h1020, 1'b0, 32'h0000_0000);
		rd(13'h100C, 1'b0, 32'h5A00_100C);
		wr(13'h1FF0, 32'hFFFF_FFFF, 1'b1);
		rd(13'h1FF0, 1'b1, 32'h0000_0000);
	endtask

	// Setup, then lock; irq 32 lockable Group 0, irq 63 out of range.
	task automatic t_lock();
		wr(13'h0104, 32'h0000_0001, 1'b1);
		@(posedge clk_sys_i);
		lock_cmd <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		#1;
		chk({31'h0, lock_act}, 32'h0000_0001);
		wr(13'h1000, 32'h0000_07FF, 1'b1);
		chk({21'h0, cpu_ctl[10:0]}, 32'h0000_0582);
		wr(13'h0000, 32'h0000_0002, 1'b1);
		rd(13'h0000, 1'b1, 32'h0000_0003);
		wr(13'h0184, 32'h0000_0003, 1'b1);
		wr(13'h0104, 32'h8000_0000, 1'b1);
		rd(13'h0104, 1'b1, 32'h8000_0001);
		wr(13'h0420, 32'h0000_50FF, 1'b1);
		rd(13'h0420, 1'b1, 32'h0000_5000);
		wr(13'h0084, 32'h0000_0003, 1'b1);
		rd(13'h0084, 1'b1, 32'h0000_0002);
		wr(13'h0084, 32'h0000_0000, 1'b1);
		wr(13'h0084, 32'h0000_0002, 1'b1);
		rd(13'h0084, 1'b1, 32'h0000_0000);
		@(posedge clk_sys_i);
		lock_cmd <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		wr(13'h0084, 32'h0000_0002, 1'b1);
		rd(13'h0084, 1'b1, 32'h0000_0002);
	endtask

	// Main sequence after a 12-cycle reset.
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_type();
		t_bank();
		t_secure_only();
		t_fields();
		t_mask();
		t_sgi_ext();
		t_lock();
		tally_and_finish();
	end

	// The run needs about 140 cycles; this cuts a hang short.
	initial
	begin
		#200000;
		errors++;
		tally_and_finish();
	end
endmodule
